// >>> rtl/wwd_watchdog.sv
// Windowed watchdog timer core with prescaler, postscaler and window.
// Assumes the core drives instruction strobes as one-cycle pulses and
// the sleep level on REF_CLK; configuration bits hold steady.
`timescale 1ns/1ps

module wwd_watchdog
    import wwd_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    input  wire logic       HARD_ENABLE_FUSE,
    input  wire logic       PRESCALE_SELECT,
    input  wire logic [3:0] POSTSCALE_SELECT,
    input  wire logic       WINDOW_DISABLE,
    input  wire logic [1:0] WINDOW_SELECT,
    input  wire logic       SOFT_ENABLE_WR,
    input  wire logic       SOFT_ENABLE_DATA,
    input  wire logic       TIMEOUT_FLAG_CLR,
    input  wire logic       CLEAR_WATCHDOG_INSTR,
    input  wire logic       POWER_SAVE_INSTR,
    input  wire logic       CLOCK_SWITCH_DONE,
    input  wire logic       SLEEP_IDLE,
    output logic            LOW_POWER_RC_OSC_ON,
    output logic            SOFT_ENABLE,
    output logic            TIMEOUT_FLAG,
    output logic            WAKE_REQ,
    output logic            DEVICE_RESET_REQ
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    wwd_state_t  q;
    wwd_state_t  n;
    logic        tick;
    logic [6:0]  pre_last;
    logic [14:0] post_last;
    logic [15:0] post_span;
    logic        pre_end;
    logic        post_end;
    logic        timeout;
    logic        clr_awake;
    logic        exit_sleep;
    logic        restart;
    logic        bad_clr;
    logic        win_open;
    // One bit wider than the longest period of 2^22 ticks
    logic [22:0] period;
    logic [22:0] elapsed;
    logic [22:0] win_start;
    logic [2:0]  pre_sh;
    logic [2:0]  win_sh;

    ////////////////////////////////////////////////////////////////////////
    // Window arithmetic
    always_comb begin
        pre_sh    = PRESCALE_SELECT ? WWD_PRE_SH_128 : WWD_PRE_SH_32;
        period    = {1'b0, (PRESCALE_SELECT ? WWD_PRE_DIV_128
                                            : WWD_PRE_DIV_32)}
                    << POSTSCALE_SELECT;
        elapsed   = ({8'h0, q.post} << pre_sh) + {16'h0, q.pre};
        win_sh    = {1'b0, WINDOW_SELECT} + WWD_WIN_SH_BASE;
        // In window mode, clearing is allowed only in the closing part of the period
        win_start = period - (period >> win_sh);
        win_open  = elapsed >= win_start;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n          = q;
        n.wake     = 1'b0;
        n.rst_req  = 1'b0;
        n.asleep_d = SLEEP_IDLE;

        if (SOFT_ENABLE_WR) begin
            n.soft_en = SOFT_ENABLE_DATA;
        end
        // Oscillator runs whenever the watchdog is enabled
        n.osc_on = HARD_ENABLE_FUSE | q.soft_en;

        // 32 kHz oscillator modelled as an enable from the system clock
        tick = q.osc_on && (q.osc_cnt == WWD_LOW_POWER_RC_OSC_LAST);
        if (!q.osc_on || tick) begin
            n.osc_cnt = WWD_OSC_ZERO;
        end else begin
            n.osc_cnt = q.osc_cnt + WWD_OSC_ONE;
        end

        pre_last  = PRESCALE_SELECT ? WWD_PRE_LAST_128
                                    : WWD_PRE_LAST_32;
        post_span = WWD_POST_UNIT << POSTSCALE_SELECT;
        post_last = 15'(post_span - WWD_POST_UNIT);
        pre_end   = q.pre == pre_last;
        post_end  = q.post == post_last;
        timeout   = tick && pre_end && post_end;

        clr_awake  = CLEAR_WATCHDOG_INSTR && !SLEEP_IDLE;
        exit_sleep = q.asleep_d && !SLEEP_IDLE;
        bad_clr    = clr_awake && q.osc_on && !WINDOW_DISABLE
                     && !win_open;
        // A disabled watchdog holds its counts at zero
        restart    = !q.osc_on | POWER_SAVE_INSTR
                     | CLOCK_SWITCH_DONE
                     | exit_sleep | clr_awake | timeout;

        if (restart) begin
            n.pre  = WWD_PRE_ZERO;
            n.post = WWD_POST_ZERO;
        end else if (tick) begin
            if (pre_end) begin
                n.pre  = WWD_PRE_ZERO;
                n.post = q.post + WWD_POST_ONE;
            end else begin
                n.pre  = q.pre + WWD_PRE_ONE;
            end
        end

        // Set wins over a clear arriving in the same cycle
        if (TIMEOUT_FLAG_CLR) begin
            n.flag = 1'b0;
        end
        if (timeout) begin
            n.flag = 1'b1;
        end

        if (timeout && SLEEP_IDLE) begin
            n.wake = 1'b1;
        end
        if ((timeout && !SLEEP_IDLE) || bad_clr) begin
            n.rst_req = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= WWD_STATE_RST;
        end else begin
            q <= n;
        end
    end

    assign LOW_POWER_RC_OSC_ON = q.osc_on;
    assign SOFT_ENABLE         = q.soft_en;
    assign TIMEOUT_FLAG        = q.flag;
    assign WAKE_REQ            = q.wake;
    assign DEVICE_RESET_REQ    = q.rst_req;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    a_osc_hard_on: assert property (
        HARD_ENABLE_FUSE |=> LOW_POWER_RC_OSC_ON
    ) else $error("oscillator off with hard enable");

    a_osc_soft_off: assert property (
        !HARD_ENABLE_FUSE && !q.soft_en |=> !LOW_POWER_RC_OSC_ON
    ) else $error("watchdog runs without any enable");

    a_pre_bound: assert property (
        q.pre <= pre_last
    ) else $error("prescaler passed its terminal count");

    a_post_bound: assert property (
        q.post <= post_last
    ) else $error("postscaler passed its terminal count");

    a_clr_counts: assert property (
        CLEAR_WATCHDOG_INSTR && !SLEEP_IDLE
        |=> q.pre == WWD_PRE_ZERO && q.post == WWD_POST_ZERO
    ) else $error("clear instruction left counts");

    a_psave_counts: assert property (
        POWER_SAVE_INSTR
        |=> q.pre == WWD_PRE_ZERO && q.post == WWD_POST_ZERO
    ) else $error("power save left counts");

    a_switch_counts: assert property (
        CLOCK_SWITCH_DONE
        |=> q.pre == WWD_PRE_ZERO && q.post == WWD_POST_ZERO
    ) else $error("clock switch left counts");

    a_exit_counts: assert property (
        $fell(SLEEP_IDLE)
        |=> q.pre == WWD_PRE_ZERO && q.post == WWD_POST_ZERO
    ) else $error("sleep exit left counts");

    a_flag_sticky: assert property (
        TIMEOUT_FLAG && !TIMEOUT_FLAG_CLR |=> TIMEOUT_FLAG
    ) else $error("timeout flag dropped by itself");

    a_flag_on_wake: assert property (
        WAKE_REQ |-> TIMEOUT_FLAG && $past(SLEEP_IDLE)
    ) else $error("wake without sleeping timeout");

    a_timeout_act: assert property (
        // A fresh early clear may raise the request again
        timeout && !SLEEP_IDLE |=> DEVICE_RESET_REQ && TIMEOUT_FLAG
            ##1 (!DEVICE_RESET_REQ || $past(bad_clr))
    ) else $error("awake timeout gave no single reset pulse");

    a_early_clear: assert property (
        CLEAR_WATCHDOG_INSTR && !SLEEP_IDLE && LOW_POWER_RC_OSC_ON
        && !WINDOW_DISABLE && !win_open |=> DEVICE_RESET_REQ
    ) else $error("early clear in window mode not punished");

    a_open_clear: assert property (
        CLEAR_WATCHDOG_INSTR && !SLEEP_IDLE && !timeout
        && (WINDOW_DISABLE || win_open) |=> !DEVICE_RESET_REQ
    ) else $error("permitted clear caused a reset");

    ////////////////////////////////////////////////////////////////////////
    // Enable, flag, wake and no-reset checks
    a_soft_write: assert property (
        SOFT_ENABLE_WR
        |=> SOFT_ENABLE == $past(SOFT_ENABLE_DATA)
    ) else $error("soft enable write not taken");

    a_soft_hold: assert property (
        !SOFT_ENABLE_WR |=> $stable(SOFT_ENABLE)
    ) else $error("soft enable changed without a write");

    a_disabled_hold: assert property (
        !LOW_POWER_RC_OSC_ON
        |=> q.pre == WWD_PRE_ZERO && q.post == WWD_POST_ZERO
    ) else $error("disabled watchdog kept counting");

    a_flag_set: assert property (
        timeout |=> TIMEOUT_FLAG
    ) else $error("timeout did not set the flag");

    a_flag_clear: assert property (
        TIMEOUT_FLAG_CLR && !timeout |=> !TIMEOUT_FLAG
    ) else $error("flag clear not taken");

    a_sleep_wake: assert property (
        timeout && SLEEP_IDLE |=> WAKE_REQ && !DEVICE_RESET_REQ
    ) else $error("sleeping timeout did not wake the core");

    a_wake_single: assert property (
        WAKE_REQ |=> !WAKE_REQ
    ) else $error("wake request longer than one cycle");

    a_sleep_no_reset: assert property (
        SLEEP_IDLE |=> !DEVICE_RESET_REQ
    ) else $error("reset requested while asleep");

    a_psave_no_reset: assert property (
        POWER_SAVE_INSTR && !CLEAR_WATCHDOG_INSTR && !timeout
        |=> !DEVICE_RESET_REQ
    ) else $error("power save caused a reset");

    a_switch_no_reset: assert property (
        CLOCK_SWITCH_DONE && !CLEAR_WATCHDOG_INSTR && !timeout
        |=> !DEVICE_RESET_REQ
    ) else $error("clock switch caused a reset");

    ////////////////////////////////////////////////////////////////////////
    // Count checks and covers
    a_pre_step: assert property (
        tick && !pre_end && !restart
        |=> q.pre == $past(q.pre) + WWD_PRE_ONE
    ) else $error("prescaler missed an oscillator tick");

    a_post_step: assert property (
        tick && pre_end && !post_end && !restart
        |=> q.post == $past(q.post) + WWD_POST_ONE
            && q.pre == WWD_PRE_ZERO
    ) else $error("postscaler missed a prescaler overflow");

    a_sleep_count: assert property (
        SLEEP_IDLE && LOW_POWER_RC_OSC_ON && tick && !pre_end
        && !POWER_SAVE_INSTR && !CLOCK_SWITCH_DONE
        |=> q.pre == $past(q.pre) + WWD_PRE_ONE
    ) else $error("prescaler stalled in sleep");

    c_awake_timeout: cover property (
        !SLEEP_IDLE ##1 DEVICE_RESET_REQ
    );

    c_sleep_wake: cover property (
        SLEEP_IDLE && WAKE_REQ
    );

    c_window_violation: cover property (
        CLEAR_WATCHDOG_INSTR && !WINDOW_DISABLE && !win_open
    );

    c_flag_race: cover property (
        timeout && TIMEOUT_FLAG_CLR
    );

    c_open_clear: cover property (
        CLEAR_WATCHDOG_INSTR && !SLEEP_IDLE && LOW_POWER_RC_OSC_ON
        && !WINDOW_DISABLE && win_open
    );

endmodule // wwd_watchdog

// >>> rtl/wwd_pkg.sv
// Constants and state type for the windowed watchdog timer.
// Assumes one 50 MHz clock; all control inputs come from that domain.
//
// Function
// - Runs from 32 kHz oscillator, enable starts it
// - Prescaler divides by 32 or 128
// - Postscaler ratio 1:1 to 1:32768, sixteen steps
// - Any device reset clears all counts
// - Completed clock switch clears all counts
// - Power save instruction clears all counts
// - Leaving sleep or idle clears all counts
// - Clear instruction clears counts when awake
// - Counts in sleep, timeout wakes core
// - Hard enable fuse forces watchdog always on
// - Otherwise soft enable bit runs the watchdog
// - Device reset forces soft enable to zero
// - Timeout flag sticky, software clears it
// - Window disable zero selects windowed clearing
package wwd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int WWD_CLK_HZ  = 50_000_000;
    localparam int WWD_LOW_POWER_RC_OSC_HZ = 32_000;
    // Longest whole cycle count fitting one oscillator period
    localparam int WWD_LOW_POWER_RC_OSC_CYC = WWD_CLK_HZ / WWD_LOW_POWER_RC_OSC_HZ;
    localparam logic [10:0] WWD_LOW_POWER_RC_OSC_LAST = 11'(WWD_LOW_POWER_RC_OSC_CYC - 1);
    localparam logic [10:0] WWD_OSC_ZERO  = 11'h0;
    localparam logic [10:0] WWD_OSC_ONE   = 11'h1;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and postscaler
    localparam logic [6:0]  WWD_PRE_LAST_32  = 7'h1f;
    localparam logic [6:0]  WWD_PRE_LAST_128 = 7'h7f;
    localparam logic [6:0]  WWD_PRE_ZERO     = 7'h0;
    localparam logic [6:0]  WWD_PRE_ONE      = 7'h1;
    localparam logic [2:0]  WWD_PRE_SH_32    = 3'h5;
    localparam logic [2:0]  WWD_PRE_SH_128   = 3'h7;
    localparam logic [21:0] WWD_PRE_DIV_32   = 22'h20;
    localparam logic [21:0] WWD_PRE_DIV_128  = 22'h80;
    localparam logic [14:0] WWD_POST_ZERO    = 15'h0;
    localparam logic [14:0] WWD_POST_ONE     = 15'h1;
    localparam logic [15:0] WWD_POST_UNIT    = 16'h1;
    localparam logic [2:0]  WWD_WIN_SH_BASE  = 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [10:0] osc_cnt;
        logic [6:0]  pre;
        logic [14:0] post;
        logic        soft_en;
        logic        osc_on;
        logic        flag;
        logic        wake;
        logic        rst_req;
        logic        asleep_d;
    } wwd_state_t;

    localparam wwd_state_t WWD_STATE_RST = '0;

endpackage

// >>> tb/tb_top.sv
// Self-checking bench for the windowed watchdog timer core.
// Assumes one 50 MHz clock; the bench drives every strobe as a pulse.
`timescale 1ns/1ps

module tb_top;
    import wwd_pkg::*;

    localparam int TO_CYC = 32 * (WWD_CLK_HZ / WWD_LOW_POWER_RC_OSC_HZ);

    logic       ref_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       fuse    = 1'b0;
    logic       win_dis = 1'b0;
    logic       sleep   = 1'b0;
    logic       sen_dat = 1'b0;
    logic [4:0] strb    = 5'h00;
    logic       pre_sel  = 1'b1;
    logic [3:0] post_sel = 4'hf;
    logic [1:0] win_sel  = 2'h3;
    logic       osc_on;
    logic       soft_en;
    logic       flag;
    logic       wake;
    logic       dev_rst;
    int         num_errors = 0;
    int         checks     = 0;
    int         cyc        = 0;
    int         t0         = 0;
    int         ts         = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    wwd_watchdog u_dut (
        .REF_CLK              (ref_clk),
        .RST_N                (rst_n),
        .HARD_ENABLE_FUSE     (fuse),
        .PRESCALE_SELECT      (pre_sel),
        .POSTSCALE_SELECT     (post_sel),
        .WINDOW_DISABLE       (win_dis),
        .WINDOW_SELECT        (win_sel),
        .SOFT_ENABLE_WR       (strb[4]),
        .SOFT_ENABLE_DATA     (sen_dat),
        .TIMEOUT_FLAG_CLR     (strb[3]),
        .CLEAR_WATCHDOG_INSTR (strb[0]),
        .POWER_SAVE_INSTR     (strb[1]),
        .CLOCK_SWITCH_DONE    (strb[2]),
        .SLEEP_IDLE           (sleep),
        .LOW_POWER_RC_OSC_ON  (osc_on),
        .SOFT_ENABLE          (soft_en),
        .TIMEOUT_FLAG         (flag),
        .WAKE_REQ             (wake),
        .DEVICE_RESET_REQ     (dev_rst)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Called just after a rising edge; the strobe is taken at the next one
    task automatic pulse(input logic [4:0] s);
        strb <= s;
        @(posedge ref_clk);
        t0 = cyc;
        strb <= 5'h00;
    endtask

    // Waits for a timeout pulse and checks the elapsed cycles
    task automatic wait_out(input int start);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (wake !== 1'b1 && dev_rst !== 1'b1 && n < 60000);
        n = cyc - start;
        checks++;
        if (n < TO_CYC - 1566 || n > TO_CYC + 4) begin
            num_errors++;
            $display("MISMATCH timeout_cycles expected %0d seen %0d",
                     TO_CYC, n);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        cmp("soft_en", 1'b0, soft_en);
        cmp("osc_on", 1'b0, osc_on);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sen_dat <= 1'b1;
        pulse(5'h10);
        @(negedge ref_clk);
        cmp("soft_en", 1'b1, soft_en);
        cmp("osc_on", 1'b0, osc_on);
        @(negedge ref_clk);
        cmp("osc_on", 1'b1, osc_on);
        @(posedge ref_clk);
        // Longest period, narrowest window: clear far too early
        pulse(5'h01);
        @(negedge ref_clk);
        cmp("dev_rst", 1'b1, dev_rst);
        @(negedge ref_clk);
        cmp("dev_rst", 1'b0, dev_rst);
        @(posedge ref_clk);
        sen_dat <= 1'b0;
        pulse(5'h10);
        repeat (2) @(negedge ref_clk);
        cmp("osc_on", 1'b0, osc_on);
        @(posedge ref_clk);
        fuse     <= 1'b1;
        win_dis  <= 1'b1;
        pre_sel  <= 1'b0;
        post_sel <= 4'h0;
        repeat (1000) @(posedge ref_clk);
        cmp("osc_on", 1'b1, osc_on);
        pulse(5'h01);
        @(negedge ref_clk);
        cmp("dev_rst", 1'b0, dev_rst);
        repeat (200) @(posedge ref_clk);
        sleep <= 1'b1;
        pulse(5'h02);
        ts = t0;
        repeat (10000) @(posedge ref_clk);
        // Clear while asleep must not restart the count
        pulse(5'h01);
        wait_out(ts);
        cmp("wake", 1'b1, wake);
        cmp("dev_rst", 1'b0, dev_rst);
        cmp("flag", 1'b1, flag);
        @(negedge ref_clk);
        cmp("wake", 1'b0, wake);
        @(posedge ref_clk);
        sleep <= 1'b0;
        pulse(5'h08);
        @(negedge ref_clk);
        cmp("flag", 1'b0, flag);
        repeat (300) @(posedge ref_clk);
        pulse(5'h04);
        wait_out(t0);
        cmp("dev_rst", 1'b1, dev_rst);
        cmp("wake", 1'b0, wake);
        cmp("flag", 1'b1, flag);
        test_done;
    end

    initial begin
        repeat (120000) @(posedge ref_clk);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        test_done;
    end

endmodule // tb_top
